/* File: hdl/setpoint_pkg.sv */
// constants and types for the converter set-point register bank
`default_nettype none
package setpoint_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CODE_W = 7;
  localparam int unsigned NREG   = 5;
  localparam int unsigned IDX_W  = 3;

  localparam logic [ADDR_W-1:0] CONV4_NORMAL_SETPOINT_OFS = 8'h94;
  localparam logic [ADDR_W-1:0] CONV4_SLEEP_SETPOINT_OFS  = 8'h95;
  localparam logic [ADDR_W-1:0] CONV5_NORMAL_SETPOINT_OFS = 8'h96;
  localparam logic [ADDR_W-1:0] CONV5_SLEEP_SETPOINT_OFS  = 8'h97;
  localparam logic [ADDR_W-1:0] CONV6_NORMAL_SETPOINT_OFS = 8'h98;

  // register index within the bank
  localparam logic [IDX_W-1:0] IDX_C4N = 3'h0;
  localparam logic [IDX_W-1:0] IDX_C4S = 3'h1;
  localparam logic [IDX_W-1:0] IDX_C5N = 3'h2;
  localparam logic [IDX_W-1:0] IDX_C5S = 3'h3;
  localparam logic [IDX_W-1:0] IDX_C6N = 3'h4;

  localparam int unsigned CODE_LSB  = 1;
  localparam int unsigned CODE_MSB  = 7;
  localparam int unsigned DECAY_BIT = 0;

  localparam logic [DATA_W-1:0] SLEEP_WMASK  = 8'hfe;
  localparam logic [DATA_W-1:0] NORMAL_WMASK = 8'hff;
  localparam logic [DATA_W-1:0] UNMAPPED_RD  = 8'h00;

  // converter six code table selector
  typedef enum logic [0:0] {
    STEP_25MV = 1'b0,
    STEP_10MV = 1'b1
  } step_range_t;
endpackage : setpoint_pkg
`default_nettype wire

/* File: hdl/setpoint_mem.sv */
// five-word register store with registered read data
`timescale 1ns/1ps
`default_nettype none
module setpoint_mem (
  input  wire logic                                clk,
  input  wire logic                                rst,
  input  wire logic [setpoint_pkg::IDX_W-1:0]      wr_idx,
  input  wire logic                                wr_en,
  input  wire logic [setpoint_pkg::DATA_W-1:0]     wr_data,
  input  wire logic [setpoint_pkg::DATA_W-1:0]     wr_mask,
  input  wire logic [setpoint_pkg::NREG*setpoint_pkg::DATA_W-1:0] dflt,
  input  wire logic [setpoint_pkg::IDX_W-1:0]      rd_idx,
  output var  logic [setpoint_pkg::DATA_W-1:0]     rd_data,
  output var  logic [setpoint_pkg::NREG*setpoint_pkg::DATA_W-1:0] words
);
  import setpoint_pkg::*;

  typedef struct packed {
    logic [NREG-1:0][DATA_W-1:0] w;
    logic [DATA_W-1:0]           rd;
  } mem_state_t;

  mem_state_t s_q;
  mem_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (rst) begin
      // factory defaults loaded by a clocked process, never by reset constant
      // word four first; only words one and three are sleep words with bit0 forced clear
      s_d.w = dflt & {NORMAL_WMASK, SLEEP_WMASK, NORMAL_WMASK, SLEEP_WMASK, NORMAL_WMASK};
      s_d.rd = UNMAPPED_RD;
    end else begin
      if (wr_en && (int'(wr_idx) < NREG)) begin
        s_d.w[wr_idx] = (wr_data & wr_mask) | (s_q.w[wr_idx] & ~wr_mask);
      end
      s_d.rd = (int'(rd_idx) < NREG) ? s_d.w[rd_idx] : UNMAPPED_RD;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign rd_data = s_q.rd;
  assign words   = s_q.w;
endmodule : setpoint_mem
`default_nettype wire

/* File: hdl/converter_setpoint_registers.sv */
// set-point register bank for converters four, five and six
// Function
// - 0x94 holds converter four normal code
// - bit0: 0 slews down, 1 decays
// - 0x95 converter four sleep code, bit0 reserved
// - 0x96 converter five normal code, decay bit
// - 0x97 converter five sleep code, bit0 reserved
// - 0x98 converter six code, 10/25 mV
`timescale 1ns/1ps
`default_nettype none
module converter_setpoint_registers (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic [setpoint_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic                              reg_wr,
  input  wire logic [setpoint_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                              reg_rd,
  output var  logic [setpoint_pkg::DATA_W-1:0]   reg_rdata,
  output var  logic                              reg_hit_q,
  input  wire logic [setpoint_pkg::NREG*setpoint_pkg::DATA_W-1:0] factory_default,
  input  wire setpoint_pkg::step_range_t         conv6_step_range,
  output var  logic [setpoint_pkg::CODE_W-1:0]   conv4_normal_code,
  output var  logic                              conv4_passive_rampdown,
  output var  logic [setpoint_pkg::CODE_W-1:0]   conv4_sleep_code,
  output var  logic [setpoint_pkg::CODE_W-1:0]   conv5_normal_code,
  output var  logic                              conv5_passive_rampdown,
  output var  logic [setpoint_pkg::CODE_W-1:0]   conv5_sleep_code,
  output var  logic [setpoint_pkg::CODE_W-1:0]   conv6_normal_code,
  output var  logic                              conv6_passive_rampdown,
  output var  setpoint_pkg::step_range_t         conv6_step_range_q
);
  import setpoint_pkg::*;

  // any index past the bank, which the store reads as unmapped
  localparam logic [IDX_W-1:0] IDX_NONE = IDX_W'(NREG);

  // offset to bank index; top bit low for unmapped offsets
  function automatic logic [IDX_W:0] decode(input logic [ADDR_W-1:0] a);
    case (a)
      CONV4_NORMAL_SETPOINT_OFS: decode = {1'b1, IDX_C4N};
      CONV4_SLEEP_SETPOINT_OFS:  decode = {1'b1, IDX_C4S};
      CONV5_NORMAL_SETPOINT_OFS: decode = {1'b1, IDX_C5N};
      CONV5_SLEEP_SETPOINT_OFS:  decode = {1'b1, IDX_C5S};
      CONV6_NORMAL_SETPOINT_OFS: decode = {1'b1, IDX_C6N};
      default:                   decode = {1'b0, IDX_C4N};
    endcase
  endfunction : decode

  function automatic logic is_sleep(input logic [IDX_W-1:0] i);
    is_sleep = (i == IDX_C4S) || (i == IDX_C5S);
  endfunction : is_sleep

  typedef struct packed {
    logic [NREG-1:0][DATA_W-1:0] out;
    logic                        hit;
    step_range_t                 rng;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  logic [IDX_W:0]             wdec;
  logic [IDX_W:0]             rdec;
  logic [DATA_W-1:0]          mem_rd;
  logic [NREG*DATA_W-1:0]     words;
  logic [DATA_W-1:0]          wmask;

  assign wdec  = decode(reg_addr);
  assign rdec  = decode(reg_addr);
  // sleep registers keep bit0 reserved and read-only
  assign wmask = is_sleep(wdec[IDX_W-1:0]) ? SLEEP_WMASK : NORMAL_WMASK;

  setpoint_mem u_mem (
    .clk     (clk),
    .rst     (rst),
    .wr_idx  (wdec[IDX_W-1:0]),
    .wr_en   (reg_wr && wdec[IDX_W]),
    .wr_data (reg_wdata),
    .wr_mask (wmask),
    .dflt    (factory_default),
    .rd_idx  (rdec[IDX_W] ? rdec[IDX_W-1:0] : IDX_NONE),
    .rd_data (mem_rd),
    .words   (words)
  );

  always_comb begin
    s_d = s_q;
    if (rst) begin
      s_d.out = '0;
      s_d.hit = 1'b0;
      s_d.rng = STEP_25MV;
    end else begin
      // outputs follow the store one cycle later, so a write shows after two edges
      s_d.out = words;
      s_d.hit = (reg_rd || reg_wr) && wdec[IDX_W];
      s_d.rng = conv6_step_range;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign reg_rdata              = mem_rd;
  assign reg_hit_q              = s_q.hit;
  assign conv4_normal_code      = s_q.out[IDX_C4N][CODE_MSB:CODE_LSB];
  assign conv4_passive_rampdown = s_q.out[IDX_C4N][DECAY_BIT];
  assign conv4_sleep_code       = s_q.out[IDX_C4S][CODE_MSB:CODE_LSB];
  assign conv5_normal_code      = s_q.out[IDX_C5N][CODE_MSB:CODE_LSB];
  assign conv5_passive_rampdown = s_q.out[IDX_C5N][DECAY_BIT];
  assign conv5_sleep_code       = s_q.out[IDX_C5S][CODE_MSB:CODE_LSB];
  assign conv6_normal_code      = s_q.out[IDX_C6N][CODE_MSB:CODE_LSB];
  assign conv6_passive_rampdown = s_q.out[IDX_C6N][DECAY_BIT];
  assign conv6_step_range_q     = s_q.rng;
endmodule : converter_setpoint_registers
`default_nettype wire

/* File: bench/converter_setpoint_registers_chk.sv */
// assertions on the set-point register bank ports
`timescale 1ns/1ps
`default_nettype none
module converter_setpoint_registers_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [39:0] factory_default,
  input wire logic [6:0]  conv4_normal_code,
  input wire logic        conv4_passive_rampdown,
  input wire logic [6:0]  conv4_sleep_code,
  input wire logic [6:0]  conv5_normal_code,
  input wire logic        conv5_passive_rampdown,
  input wire logic [6:0]  conv5_sleep_code,
  input wire logic [6:0]  conv6_normal_code,
  input wire logic        conv6_passive_rampdown
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  property p_c4n; s_wr(8'h94) |-> ##2 conv4_normal_code == $past(reg_wdata[7:1], 2); endproperty
  property p_c4d; s_wr(8'h94) |-> ##2 conv4_passive_rampdown == $past(reg_wdata[0], 2); endproperty
  property p_c4s; s_wr(8'h95) |-> ##2 conv4_sleep_code == $past(reg_wdata[7:1], 2); endproperty
  property p_c5n; s_wr(8'h96) |-> ##2 {conv5_normal_code, conv5_passive_rampdown} == $past(reg_wdata, 2); endproperty
  property p_c5s; s_wr(8'h97) |-> ##2 conv5_sleep_code == $past(reg_wdata[7:1], 2); endproperty
  property p_c6n; s_wr(8'h98) |-> ##2 {conv6_normal_code, conv6_passive_rampdown} == $past(reg_wdata, 2); endproperty
  // reserved bit must read zero even when written one
  property p_rsv; s_wr(8'h97) |=> reg_rdata == {$past(reg_wdata[7:1]), 1'b0}; endproperty
  // outputs read zero while reset is held, defaults show one edge after release
  sequence s_rst_end;
    rst ##1 !rst;
  endsequence
  property p_rst;
    disable iff (1'b0) s_rst_end |=> conv4_sleep_code == $past(factory_default[15:9], 2);
  endproperty
  property p_rst6;
    disable iff (1'b0) s_rst_end |=> conv6_passive_rampdown == $past(factory_default[32], 2);
  endproperty
  a_c4n: assert property (p_c4n) else $error("normal code four wrong");
  a_c4d: assert property (p_c4d) else $error("rampdown four wrong");
  a_c4s: assert property (p_c4s) else $error("sleep code four wrong");
  a_c5n: assert property (p_c5n) else $error("normal code five wrong");
  a_c5s: assert property (p_c5s) else $error("sleep code five wrong");
  a_c6n: assert property (p_c6n) else $error("normal code six wrong");
  a_rsv: assert property (p_rsv) else $error("reserved bit not zero");
  a_rst: assert property (p_rst) else $error("reset default missing");
  a_rst6: assert property (p_rst6) else $error("reset rampdown six default missing");
endmodule : converter_setpoint_registers_chk
bind converter_setpoint_registers converter_setpoint_registers_chk i_converter_setpoint_registers_chk (
  .clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .factory_default, .conv4_normal_code,
  .conv4_passive_rampdown, .conv4_sleep_code, .conv5_normal_code, .conv5_passive_rampdown,
  .conv5_sleep_code, .conv6_normal_code, .conv6_passive_rampdown);
`default_nettype wire

/* File: bench/converter_setpoint_registers_test.sv */
// self-checking bench for the set-point register bank
`timescale 1ns/1ps
`default_nettype none
module converter_setpoint_registers_test;
  import setpoint_pkg::*;
  typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} row_t;
  logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, reg_hit_q, d4, d5, d6;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [6:0]  c4n, c4s, c5n, c5s, c6n;
  logic [39:0] factory_default = 40'h1122334455, outs;
  step_range_t conv6_step_range = STEP_25MV, conv6_step_range_q;
  int          error_cnt = 0, compares = 0, cyc = 0, i;
  row_t rows [8] = '{'{8'h94, 1'b1, 8'h81, 8'h81}, '{8'h95, 1'b1, 8'hff, 8'hfe}, '{8'h96, 1'b1, 8'h2a, 8'h2a},
    '{8'h97, 1'b1, 8'h55, 8'h54}, '{8'h98, 1'b1, 8'hc3, 8'hc3}, '{8'h99, 1'b1, 8'hff, 8'h00},
    '{8'h93, 1'b0, 8'h00, 8'h00}, '{8'h94, 1'b0, 8'h00, 8'h81}};
  assign outs = {2'h0, c4n, d4, c4s, c5n, d5, c5s, c6n, d6};
  converter_setpoint_registers i_converter_setpoint_registers (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit_q(reg_hit_q),
    .factory_default(factory_default), .conv6_step_range(conv6_step_range), .conv4_normal_code(c4n),
    .conv4_passive_rampdown(d4), .conv4_sleep_code(c4s), .conv5_normal_code(c5n),
    .conv5_passive_rampdown(d5), .conv5_sleep_code(c5s), .conv6_normal_code(c6n),
    .conv6_passive_rampdown(d6), .conv6_step_range_q(conv6_step_range_q));
  task chk(input logic [39:0] g, input logic [39:0] x);
    compares++;
    if (g !== x) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task wrap_up;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial forever #5 clk = ~clk;
  // generous ceiling, the whole run is some eighteen cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 200) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1 chk(outs, {2'h0, 8'h55, 7'h22, 8'h33, 7'h11, 8'h11});
    // back to back accesses, each checked one edge later
    for (i = 0; i <= 8; i++) begin
      @(posedge clk);
      if (i < 8) begin
        reg_addr <= rows[i].a;
        reg_wr <= rows[i].w;
        reg_rd <= !rows[i].w;
        reg_wdata <= rows[i].d;
      end else begin
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        conv6_step_range <= STEP_10MV;
      end
      #1;
      if (i > 0) begin
        chk({32'h0, reg_rdata}, {32'h0, rows[i-1].e});
        chk({39'h0, reg_hit_q}, {39'h0, rows[i-1].a inside {[8'h94:8'h98]}});
      end
    end
    @(posedge clk);
    #1 chk(outs, {2'h0, 8'h81, 7'h7f, 8'h2a, 7'h2a, 8'hc3});
    chk({39'h0, conv6_step_range_q}, {39'h0, STEP_10MV});
    @(posedge clk);
    rst <= 1;
    factory_default <= 40'h99887767ff;
    reg_addr <= 8'h95;
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1 chk({32'h0, reg_rdata}, 40'h66);
    chk(outs, {2'h0, 8'hff, 7'h33, 8'h77, 7'h44, 8'h99});
    wrap_up();
  end
endmodule : converter_setpoint_registers_test
`default_nettype wire
